// file: hw/mzph_pkg.sv
package mzph_pkg;
  // Spare line layout: four differential pairs, each usable as two wires
  localparam int SPARE_PAIRS = 4;
  localparam int SPARE_LINES = 2 * SPARE_PAIRS;
  // Register offsets on the Avalon-MM slave (byte addresses)
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_SPARE_WR = 4'h8;
  localparam logic [3:0] REG_SPARE_RD = 4'hC;
  // Control register fields
  localparam int CTRL_REPOWER  = 0;
  localparam int CTRL_SPARE_OE = 1;
  localparam int CTRL_SPARE_PC = 2;
  // Status register fields
  localparam int ST_PRESENT = 0;
  localparam int ST_PERMIT  = 1;
  localparam int ST_GOOD    = 2;
  localparam int ST_DONE    = 3;
  localparam int ST_READY   = 4;
  localparam int ST_SPC_IN  = 5;
  localparam int ST_STATE   = 6;
  // Reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0002;
  localparam logic [7:0]  SPARE_RESET = 8'h00;
  // Re-power-up: permit held low this long before it may rise again
  localparam int REPOWER_US     = 1000;
  localparam int CLK_MHZ        = 10;
  localparam int REPOWER_CYCLES = REPOWER_US * CLK_MHZ;
  // Hub sequencer states
  typedef enum logic [1:0] {
    MZPH_OFF     = 2'b00,
    MZPH_PERMIT  = 2'b01,
    MZPH_REPOWER = 2'b10
  } mzph_state_t;
endpackage

// file: hw/mzph_link_if.sv
`timescale 1ns/10ps
// Pins between hub and mezzanine; open pins resolved by the bench
interface mzph_link_if;
  import mzph_pkg::*;
  logic                   card_present_n;
  logic                   power_up_permit;
  logic                   supplies_good;
  logic                   config_done;
  logic                   spc_hub_o;
  logic                   spc_hub_oe;
  logic                   spc_card_o;
  logic                   spc_card_oe;
  logic                   spare_power_ctrl;
  logic [SPARE_LINES-1:0] spare_o;
  logic [SPARE_LINES-1:0] spare_oe;
  logic [SPARE_LINES-1:0] spare_line;
  modport hub (
    input  card_present_n, supplies_good, config_done, spare_power_ctrl,
    input  spare_line,
    output power_up_permit, spc_hub_o, spc_hub_oe, spare_o, spare_oe
  );
  modport card (
    input  power_up_permit, spare_power_ctrl, spare_line,
    output card_present_n, supplies_good, config_done, spc_card_o,
    output spc_card_oe
  );
endinterface

// file: hw/mzph_card.sv
`timescale 1ns/10ps
// Mezzanine end: waits for permit, reports supplies and configuration
module mzph_card
  import mzph_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // Link to hub
  mzph_link_if.card           link,
  // Local user side
  input  wire logic           rails_ok,
  input  wire logic           cfg_ok,
  output logic                rails_enable,
  output logic [SPARE_LINES-1:0] spare_seen
);
  logic                   permit_m_q, permit_q;
  logic [SPARE_LINES-1:0] spare_m_q, spare_q;
  logic                   en_d, en_q, good_d, good_q, done_d, done_q;

  // Synchronise hub-driven inputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      permit_m_q <= 1'b0;
      permit_q   <= 1'b0;
      spare_m_q  <= SPARE_RESET;
      spare_q    <= SPARE_RESET;
    end else begin
      permit_m_q <= link.power_up_permit;
      permit_q   <= permit_m_q;
      spare_m_q  <= link.spare_line;
      spare_q    <= spare_m_q;
    end
  end

  // Power only while permitted; status follows real rails
  always_comb begin
    en_d   = permit_q;
    good_d = en_q & rails_ok;
    done_d = good_d & cfg_ok;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q   <= 1'b0;
      good_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      en_q   <= en_d;
      good_q <= good_d;
      done_q <= done_d;
    end
  end

  assign link.card_present_n = 1'b0;        // Card fitted pulls line low
  assign link.supplies_good  = good_q;
  assign link.config_done    = done_q;
  assign link.spc_card_o     = 1'b0;
  assign link.spc_card_oe    = 1'b0;         // Spare control left to hub
  assign rails_enable        = en_q;
  assign spare_seen          = spare_q;      // Spare lines only read
endmodule

// file: hw/mzph_hub.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - Presence line low means card fitted
// - Permit only after FPGA configured, clocks running
// - Permit only after shelf manager authorisation
// - Card may wait for permit before powering
// - Permit holds until off, supply loss, re-power
// - Card raises supplies-good once rails in range
// - Ignore card inputs until supplies-good
// - Card raises config-done when fully configured
// - Withhold hub ready until config-done
// - Spare lines hub-driven, card receives only
// - Spare drivers off without supplies-good
// - Four pairs, each differential or two singles; the code has no differential mode and drives eight single lines
// - Spare lines reachable through software registers
module mzph_hub
  import mzph_pkg::*;
#(
  parameter int REPOWER_CNT = REPOWER_CYCLES
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Hub environment
  input  wire logic        fpga_configured,
  input  wire logic        clocks_running,
  input  wire logic        shelf_power_ok,
  input  wire logic        backplane_ok,
  output logic             hub_ready,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link to mezzanine
  mzph_link_if.hub         link
);
  // Two-stage synchronisers for all card-side and pin inputs
  logic [3+SPARE_LINES:0] sync_m_q, sync_q, sync_in;
  logic present, good, done, spc_in;
  logic [SPARE_LINES-1:0] spare_in;

  assign sync_in = {link.spare_line, link.spare_power_ctrl,
                    link.config_done, link.supplies_good,
                    link.card_present_n};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_m_q <= '0;
      sync_q   <= '0;
    end else begin
      sync_m_q <= sync_in;
      sync_q   <= sync_m_q;
    end
  end

  // Supplies-good qualifies every other card input except presence
  always_comb begin
    present  = ~sync_q[0];
    good     = present & sync_q[1];
    done     = good & sync_q[2];
    spc_in   = good & sync_q[3];
    spare_in = good ? sync_q[4 +: SPARE_LINES] : '0;
  end

  // Sequencer for the permit line
  mzph_state_t state_d, state_q;
  logic [31:0] cnt_d, cnt_q;
  logic        permit_d, permit_q;
  logic        ready_d, ready_q;
  logic [31:0] ctrl_d, ctrl_q;
  logic        repower_req;
  logic        hub_up;

  assign hub_up = fpga_configured & clocks_running & shelf_power_ok &
                  backplane_ok;
  // Repower is a level request; software clears it to let permit rise again
  assign repower_req = ctrl_q[CTRL_REPOWER];

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    case (state_q)
      MZPH_OFF: begin
        if (hub_up && !repower_req) begin
          state_d = MZPH_PERMIT;
        end
      end
      MZPH_PERMIT: begin
        if (!shelf_power_ok || !backplane_ok) begin
          state_d = MZPH_OFF;
        end else if (repower_req) begin
          state_d = MZPH_REPOWER;
          cnt_d   = 32'(REPOWER_CNT);
        end
      end
      MZPH_REPOWER: begin
        if (cnt_q != 32'h0000_0000) begin
          cnt_d = cnt_q - 32'h0000_0001;
        end else begin
          state_d = MZPH_OFF;
        end
      end
      default: begin
        state_d = MZPH_OFF;
      end
    endcase
    // Permit follows the next state so it moves with state_q
    permit_d = (state_d == MZPH_PERMIT);
    ready_d  = permit_d & done;
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q  <= MZPH_OFF;
      cnt_q    <= 32'h0000_0000;
      permit_q <= 1'b0;
      ready_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      permit_q <= permit_d;
      ready_q  <= ready_d;
    end
  end

  // Register file: one-cycle waitrequest then answer
  logic [SPARE_LINES-1:0] spare_wr_d, spare_wr_q;
  logic [31:0]            rdata_d, rdata_q;
  logic                   wait_d, wait_q;
  logic [SPARE_LINES-1:0] spare_oe_d, spare_oe_q, spare_o_d, spare_o_q;
  logic                   spc_o_d, spc_o_q, spc_oe_d, spc_oe_q;
  logic                   acc;
  logic                   wr_take;

  assign acc = (avs_read | avs_write) & wait_q;
  assign wr_take = avs_write & ~wait_q & avs_byteenable[0];

  always_comb begin
    ctrl_d     = ctrl_q;
    spare_wr_d = spare_wr_q;
    rdata_d    = rdata_q;
    wait_d     = 1'b1;
    // First edge of a request: answer is prepared, waitrequest drops
    if (acc) begin
      wait_d = 1'b0;
      case (avs_address)
        REG_CTRL:     rdata_d = ctrl_q;
        REG_STATUS:   rdata_d = {24'h00_0000, state_q, spc_in, ready_q,
                                 done, good, permit_q, present};
        REG_SPARE_WR: rdata_d = {24'h00_0000, spare_wr_q};
        REG_SPARE_RD: rdata_d = {24'h00_0000, spare_in};
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
    // Writes land only on the edge that sees waitrequest low, so a
    // request dropped early never changes a register; byte lane 0 only
    if (wr_take) begin
      case (avs_address)
        REG_CTRL:     ctrl_d = {29'h000_0000, avs_writedata[2:0]};
        REG_SPARE_WR: spare_wr_d = avs_writedata[7:0];
        default:      ;
      endcase
    end
    // Drive spares only while the card reports good supplies
    spare_oe_d = {SPARE_LINES{good & ctrl_q[CTRL_SPARE_OE]}};
    spare_o_d  = spare_wr_q;
    spc_oe_d   = good;
    spc_o_d    = ctrl_q[CTRL_SPARE_PC];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q     <= CTRL_RESET;
      spare_wr_q <= SPARE_RESET;
      rdata_q    <= 32'h0000_0000;
      wait_q     <= 1'b1;
      spare_oe_q <= '0;
      spare_o_q  <= SPARE_RESET;
      spc_o_q    <= 1'b0;
      spc_oe_q   <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      spare_wr_q <= spare_wr_d;
      rdata_q    <= rdata_d;
      wait_q     <= wait_d;
      spare_oe_q <= spare_oe_d;
      spare_o_q  <= spare_o_d;
      spc_o_q    <= spc_o_d;
      spc_oe_q   <= spc_oe_d;
    end
  end

  // Every output leaves straight from a flop
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
  assign hub_ready             = ready_q;
  assign link.power_up_permit  = permit_q;
  assign link.spare_o          = spare_o_q;
  assign link.spare_oe         = spare_oe_q;
  assign link.spc_hub_o        = spc_o_q;
  assign link.spc_hub_oe       = spc_oe_q;
endmodule

// file: tb/mzph_props.sv
`timescale 1ns/10ps
// Checks the hub side of the link and its bus handshake
module mzph_props
  import mzph_pkg::*;
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // Hub environment and bus
  input wire logic                   fpga_configured,
  input wire logic                   clocks_running,
  input wire logic                   shelf_power_ok,
  input wire logic                   backplane_ok,
  input wire logic                   hub_ready,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  // Link pins
  input wire logic                   power_up_permit,
  input wire logic                   supplies_good,
  input wire logic                   config_done,
  input wire logic [SPARE_LINES-1:0] spare_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Recent legal causes of a permit drop; any write may be a repower
  logic [5:0] cause_q;
  logic [5:0] cause_d;
  always_comb cause_d = {cause_q[4:0],
                         !shelf_power_ok || !backplane_ok || avs_write};
  always_ff @(posedge ref_clk) cause_q <= rst ? 6'h00 : cause_d;
  sequence s_card_up;
    (config_done && supplies_good && power_up_permit) [*6];
  endsequence
  AST_SPARE_OFF: assert property (
    !supplies_good [*4] |-> spare_oe == '0)
    else $error("spare drivers on without supplies good");
  AST_PERMIT_ENV: assert property (
    $rose(power_up_permit) |->
      $past(fpga_configured && clocks_running && shelf_power_ok))
    else $error("permit rose before hub was up");
  AST_PERMIT_HOLD: assert property (
    $fell(power_up_permit) |-> |cause_q)
    else $error("permit dropped without cause");
  AST_READY_DONE: assert property (
    hub_ready |-> $past(config_done, 3))
    else $error("ready without config done");
  AST_READY_RISE: assert property (
    s_card_up |-> hub_ready)
    else $error("ready missing after card up");
  AST_GOOD_GATES: assert property (
    !supplies_good [*4] |-> !hub_ready)
    else $error("card input used without supplies good");
  AST_WAIT_ANS: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_ONE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
endmodule

// file: tb/tb_mezzanine_power_handshake.sv
`timescale 1ns/10ps
module tb_mezzanine_power_handshake;
  import mzph_pkg::*;
  // Clock, reset, environment and bus
  logic        ref_clk         = 1'b0;
  logic        rst             = 1'b1;
  logic        fpga_configured = 1'b0;
  logic        clocks_running  = 1'b0;
  logic        shelf_power_ok  = 1'b0;
  logic        backplane_ok    = 1'b0;
  logic        rails_ok        = 1'b0;
  logic        cfg_ok          = 1'b0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [3:0]  avs_address     = 4'h0;
  logic [3:0]  avs_byteenable  = 4'hf;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, hub_ready, rails_enable;
  logic [7:0]  spare_seen;
  logic [31:0] lfsr            = 32'h3bc4_15ed;
  int          n_errors        = 0;
  int          checked         = 0;
  always #50 ref_clk = ~ref_clk;
  mzph_link_if lk ();
  // Undriven lines show the inverse of the last drive, never a held value
  assign lk.spare_line = ~(lk.spare_o ^ lk.spare_oe);
  assign lk.spare_power_ctrl = lk.spc_hub_oe ? lk.spc_hub_o :
    (lk.spc_card_oe ? lk.spc_card_o : ~lk.spc_hub_o);
  mzph_hub #(.REPOWER_CNT(8)) mzph_hub_inst (.ref_clk, .rst,
    .fpga_configured, .clocks_running, .shelf_power_ok, .backplane_ok,
    .hub_ready, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .link(lk));
  mzph_card mzph_card_inst (.ref_clk, .rst, .link(lk), .rails_ok, .cfg_ok,
    .rails_enable, .spare_seen);
  mzph_props mzph_props_inst (.ref_clk, .rst, .fpga_configured,
    .clocks_running, .shelf_power_ok, .backplane_ok, .hub_ready, .avs_read,
    .avs_write, .avs_waitrequest, .power_up_permit(lk.power_up_permit),
    .supplies_good(lk.supplies_good), .config_done(lk.config_done),
    .spare_oe(lk.spare_oe));
  // Report and end
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    logic [3:0] v;
    v = {lk.spare_oe[0], hub_ready, rails_enable, lk.power_up_permit};
    return v[s];
  endfunction
  // Bounded wait; a run-out counts and ends the run
  task automatic wait_for(input int s, input logic v);
    int i;
    for (i = 0; i < 60 && pick(s) !== v; i++) @(posedge ref_clk);
    if (i == 60) begin
      n_errors++;
      $display("ERROR %0t wait timed out", $time);
      conclude();
    end
  endtask
  // One Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++) @(posedge ref_clk);
    if (i == 20) begin
      n_errors++;
      $display("ERROR %0t bus answer timed out", $time);
      conclude();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Let an edge pass so a following call never reassigns in this step
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Main sequence
  initial begin
    int k;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    fpga_configured <= 1'b1;
    clocks_running <= 1'b1;
    backplane_ok <= 1'b1;
    repeat (6) @(posedge ref_clk);
    cmp(lk.power_up_permit, 0);
    shelf_power_ok <= 1'b1;
    clocks_running <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp(lk.power_up_permit, 0);
    clocks_running <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(1, 1'b1);
    cmp(rails_enable, 1);
    cmp(lk.spare_oe, 0);
    rails_ok <= 1'b1;
    cfg_ok <= 1'b1;
    wait_for(2, 1'b1);
    cmp(lk.spare_oe, 32'hff);
    // The hub's own spare control drive needs its sync delay to settle
    repeat (3) @(posedge ref_clk);
    bus(1'b0, REG_STATUS, 0);
    cmp(rd, 32'h0000_005f);
    for (k = 0; k < 5; k++) begin
      lfsr = nxt(lfsr);
      bus(1'b1, REG_SPARE_WR, k == 0 ? 32'h0000_00ff : lfsr);
      repeat (4) @(posedge ref_clk);
      cmp(spare_seen, k == 0 ? 32'hff : lfsr[7:0]);
      bus(1'b0, REG_SPARE_RD, 0);
      cmp(rd, k == 0 ? 32'hff : lfsr[7:0]);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, REG_SPARE_WR, ~lfsr);
    avs_byteenable <= 4'hf;
    bus(1'b0, REG_SPARE_WR, 0);
    cmp(rd, {24'h00_0000, lfsr[7:0]});
    bus(1'b1, REG_CTRL, 32'h0000_0006);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, REG_STATUS, 0);
    cmp(rd, 32'h0000_007f);
    bus(1'b0, 4'h2, 0);
    cmp(rd, 0);
    rails_ok <= 1'b0;
    wait_for(3, 1'b0);
    wait_for(2, 1'b0);
    cmp(lk.spare_oe, 0);
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    wait_for(0, 1'b0);
    repeat (12) @(posedge ref_clk);
    cmp(lk.power_up_permit, 0);
    bus(1'b1, REG_CTRL, CTRL_RESET);
    for (k = 0; k < 2; k++) begin
      wait_for(0, 1'b1);
      if (k == 0)
        shelf_power_ok <= 1'b0;
      else
        backplane_ok <= 1'b0;
      wait_for(0, 1'b0);
      shelf_power_ok <= 1'b1;
      cmp(hub_ready, 0);
    end
    conclude();
  end
endmodule
